// ### rtl/tcd_dma.sv
// two-channel dma controller: registers, arbitration, fetch/deposit sequencer
`timescale 1ns/1ns
// How it works
// - six registers per channel: addresses, count, control
// - count holds remaining transfers, up to 64k
// - software writes take effect at once, any time
// - control selects sync mode and byte/word size
// - optional interrupt after last transfer completes
// - control bit: stop at zero count or continue
// - source space and source step from control
// - destination space and destination step from control
// - fixed priority or alternate when both request
// - dma beats cpu except locked/odd-word halves
// - external hold request wins over dma
// - cpu locked off bus during dma cycle
// - nmi holds off new dma cycles on both channels; a running cycle still ends
// - back-to-back cycles keep documented throughput
// - request from pin, timer 2 or software
// - transfer is fetch then deposit, nine clocks min
// - any space pair, bytes or words, any alignment
module tcd_dma (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  pcb_sel,
  input  wire logic                  pcb_wr,
  input  wire logic [3:0]            pcb_addr,
  input  wire logic [15:0]           pcb_wdata,
  output logic [15:0]                pcb_rdata,
  input  wire logic [1:0]            channel_request_pins,
  input  wire logic                  timer2_out,
  input  wire logic                  nmi_req,
  input  wire logic                  hold_req,
  input  wire logic                  cpu_locked,
  input  wire logic                  cpu_odd_split,
  output tcd_pkg::tcd_bus_cmd_t      bus_cmd,
  output logic                       bus_cmd_valid,
  input  wire logic                  bus_done,
  input  wire logic [15:0]           bus_rdata,
  output logic                       dma_owns_bus,
  output logic [1:0]                 dma_irq
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_FETCH   = 3'b010,
    ST_DEPOSIT = 3'b100
  } tcd_state_t;

  tcd_state_t             state_ff;
  tcd_state_t             nxt_state;
  tcd_pkg::tcd_ctrl_t     ctrl_ff [2];
  logic [19:0]            src_ff [2];
  logic [19:0]            dst_ff [2];
  logic [15:0]            cnt_ff [2];
  logic [1:0]             pend_ff;
  logic [1:0]             req;
  logic [1:0]             fetch_ok;
  logic                   last_ff;
  logic                   cur_ch_ff;
  logic                   pick;
  logic                   blocked;
  logic                   dep_ok;
  logic                   start_fet;
  logic                   start_dep;
  logic                   fin;
  logic                   fetch_fin;
  logic                   dep_fin;
  logic                   done_seen_ff;
  logic [2:0]             cyc_cnt_ff;
  logic [15:0]            rdata_ff;
  logic [15:0]            rd_val;
  tcd_pkg::tcd_bus_cmd_t  bus_cmd_ff;
  logic                   bus_cmd_valid_ff;
  logic                   owns_ff;
  logic [1:0]             irq_ff;
  logic [15:0]            pcb_rdata_ff;
  tcd_pkg::tcd_buf_ent_t  buf_ff [2];
  logic                   buf_wp_ff;
  logic                   buf_rp_ff;
  logic [1:0]             buf_cnt_ff;
  logic                   buf_in_valid;
  logic                   buf_in_ready;
  logic                   buf_out_valid;
  logic                   buf_out_ready;
  tcd_pkg::tcd_buf_ent_t  head;

  // next address after one transfer; odd or even start alike
  function automatic logic [19:0] step_addr(
    input logic [19:0]        a,
    input tcd_pkg::tcd_step_t s,
    input logic               w
  );
    logic [19:0] inc;
    inc = w ? 20'h00002 : 20'h00001;
    unique case (s)
      tcd_pkg::STEP_INC: step_addr = a + inc;
      tcd_pkg::STEP_DEC: step_addr = a - inc;
      default:           step_addr = a;
    endcase
  endfunction : step_addr

  // ==========================================================================
  // request selection and per-channel readiness
  // ==========================================================================
  for (genvar i = 0; i < 2; i++)
  begin : g_req
    // one of three request sources per channel
    always_comb
    begin
      unique case (ctrl_ff[i].req_src)
        tcd_pkg::RQ_PIN:    req[i] = channel_request_pins[i];
        tcd_pkg::RQ_TIMER2: req[i] = timer2_out;
        tcd_pkg::RQ_SOFT:   req[i] = ctrl_ff[i].sw_req;
        default:            req[i] = 1'b0;
      endcase
    end
    // unsynchronized channels run free; source sync waits on the request
    assign fetch_ok[i] = ctrl_ff[i].arm && !pend_ff[i]
                         && (ctrl_ff[i].sync != tcd_pkg::SYNC_SRC || req[i]);
  end

  // ==========================================================================
  // arbitration
  // ==========================================================================
  // the bus is not taken from hold, nmi, a locked sequence or a split word
  assign blocked = nmi_req
                 || hold_req
                 || cpu_locked
                 || cpu_odd_split;

  // differing priorities: the high one wins; equal: alternate on contention
  always_comb
  begin
    if (fetch_ok == 2'b11)
    begin
      if (ctrl_ff[0].prio_hi != ctrl_ff[1].prio_hi)
        pick = ctrl_ff[1].prio_hi;
      else
        pick = !last_ff;
    end
    else
      pick = fetch_ok[1];
  end

  assign head      = buf_ff[buf_rp_ff];
  assign dep_ok    = buf_out_valid
                     && (ctrl_ff[head.ch].sync != tcd_pkg::SYNC_DST || req[head.ch]);
  // a ready deposit goes first; fetched data piles up only while a destination waits
  assign start_dep = state_ff == ST_IDLE && !blocked && dep_ok;
  assign start_fet = state_ff == ST_IDLE && !blocked && !dep_ok
                     && (fetch_ok != 2'b00) && buf_in_ready;

  // a bus cycle ends once the unit answered and the minimum length passed
  assign fin       = done_seen_ff && cyc_cnt_ff >= (tcd_pkg::CYC_MIN_CLKS - 3'h1);
  assign fetch_fin = state_ff == ST_FETCH && fin;
  assign dep_fin   = state_ff == ST_DEPOSIT && fin;

  // ==========================================================================
  // sequencer: idle -> fetch -> idle -> deposit, one idle clock in between
  // ==========================================================================
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (start_dep)
          nxt_state = ST_DEPOSIT;
        else if (start_fet)
          nxt_state = ST_FETCH;
      end
      ST_FETCH:   if (fin) nxt_state = ST_IDLE;
      ST_DEPOSIT: if (fin) nxt_state = ST_IDLE;
      default:    nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // bus cycle length counter and answer capture
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cyc_cnt_ff   <= 3'h0;
      done_seen_ff <= 1'b0;
      rdata_ff     <= 16'h0000;
    end
    else if (state_ff == ST_IDLE || fin)
    begin
      cyc_cnt_ff   <= 3'h0;
      done_seen_ff <= 1'b0;
    end
    else
    begin
      if (cyc_cnt_ff != 3'h7)
        cyc_cnt_ff <= cyc_cnt_ff + 3'h1;
      if (bus_cmd_valid_ff && bus_done)
      begin
        done_seen_ff <= 1'b1;
        rdata_ff     <= bus_rdata;
      end
    end
  end

  // bus command: fetch reads the source, deposit writes the destination
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_cmd_ff       <= '0;
      bus_cmd_valid_ff <= 1'b0;
      cur_ch_ff        <= 1'b0;
      last_ff          <= 1'b0;
    end
    else if (start_fet)
    begin
      bus_cmd_ff.addr  <= src_ff[pick];
      bus_cmd_ff.io    <= ctrl_ff[pick].src_io;
      bus_cmd_ff.word  <= ctrl_ff[pick].word;
      bus_cmd_ff.write <= 1'b0;
      bus_cmd_ff.wdata <= 16'h0000;
      bus_cmd_valid_ff <= 1'b1;
      cur_ch_ff        <= pick;
      last_ff          <= pick;
    end
    else if (start_dep)
    begin
      bus_cmd_ff.addr  <= dst_ff[head.ch];
      bus_cmd_ff.io    <= ctrl_ff[head.ch].dst_io;
      bus_cmd_ff.word  <= ctrl_ff[head.ch].word;
      bus_cmd_ff.write <= 1'b1;
      bus_cmd_ff.wdata <= head.data;
      bus_cmd_valid_ff <= 1'b1;
      cur_ch_ff        <= head.ch;
    end
    else if (bus_done)
      bus_cmd_valid_ff <= 1'b0;
  end

  // cpu keeps off the bus from issue to end; interrupts do not cut in
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      owns_ff <= 1'b0;
    else
      owns_ff <= nxt_state != ST_IDLE;
  end

  // ==========================================================================
  // two-entry buffer between fetch and deposit
  // ==========================================================================
  // a destination that stalls lets the other channel fetch, so it can fill
  assign buf_in_valid  = fetch_fin;
  assign buf_in_ready  = buf_cnt_ff != tcd_pkg::BUF_DEPTH;
  assign buf_out_valid = buf_cnt_ff != 2'h0;
  assign buf_out_ready = dep_fin;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buf_wp_ff  <= 1'b0;
      buf_rp_ff  <= 1'b0;
      buf_cnt_ff <= 2'h0;
      buf_ff[0]  <= '0;
      buf_ff[1]  <= '0;
    end
    else
    begin
      if (buf_in_valid && buf_in_ready)
      begin
        buf_ff[buf_wp_ff] <= '{ch: cur_ch_ff, data: rdata_ff};
        buf_wp_ff         <= !buf_wp_ff;
      end
      if (buf_out_valid && buf_out_ready)
        buf_rp_ff <= !buf_rp_ff;
      unique case ({buf_in_valid && buf_in_ready, buf_out_valid && buf_out_ready})
        2'b10:   buf_cnt_ff <= buf_cnt_ff + 2'h1;
        2'b01:   buf_cnt_ff <= buf_cnt_ff - 2'h1;
        default: buf_cnt_ff <= buf_cnt_ff;
      endcase
    end
  end

  // ==========================================================================
  // channel registers: software write wins over the hardware update
  // ==========================================================================
  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    logic we;
    logic fet_i;
    logic dep_i;
    logic is_last;
    assign we      = pcb_sel && pcb_wr && pcb_addr[3] == 1'(i);
    assign fet_i   = fetch_fin && cur_ch_ff == 1'(i);
    assign dep_i   = dep_fin && cur_ch_ff == 1'(i);
    // count of zero at start means a full 64k run when terminating
    assign is_last = ctrl_ff[i].term_en && cnt_ff[i] == 16'h0001;

    // source address: low word and top nibble written apart
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        src_ff[i] <= tcd_pkg::ADDR_RST;
      else if (we && pcb_addr[2:0] == tcd_pkg::REG_SRC_LO)
        src_ff[i] <= {src_ff[i][19:16], pcb_wdata};
      else if (we && pcb_addr[2:0] == tcd_pkg::REG_SRC_HI)
        src_ff[i] <= {pcb_wdata[3:0], src_ff[i][15:0]};
      else if (fet_i)
        src_ff[i] <= step_addr(src_ff[i], ctrl_ff[i].src_step, ctrl_ff[i].word);
    end

    // destination address
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        dst_ff[i] <= tcd_pkg::ADDR_RST;
      else if (we && pcb_addr[2:0] == tcd_pkg::REG_DST_LO)
        dst_ff[i] <= {dst_ff[i][19:16], pcb_wdata};
      else if (we && pcb_addr[2:0] == tcd_pkg::REG_DST_HI)
        dst_ff[i] <= {pcb_wdata[3:0], dst_ff[i][15:0]};
      else if (dep_i)
        dst_ff[i] <= step_addr(dst_ff[i], ctrl_ff[i].dst_step, ctrl_ff[i].word);
    end

    // transfer count: one less per completed transfer, wraps when not ending
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        cnt_ff[i] <= tcd_pkg::COUNT_RST;
      else if (we && pcb_addr[2:0] == tcd_pkg::REG_COUNT)
        cnt_ff[i] <= pcb_wdata;
      else if (dep_i)
        cnt_ff[i] <= cnt_ff[i] - 16'h0001;
    end

    // control: the last transfer of a terminating run disarms the channel
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        ctrl_ff[i] <= tcd_pkg::tcd_ctrl_t'(tcd_pkg::CTRL_RST);
      else if (we && pcb_addr[2:0] == tcd_pkg::REG_CTRL)
        ctrl_ff[i] <= tcd_pkg::tcd_ctrl_t'(pcb_wdata);
      else if (dep_i && is_last)
        ctrl_ff[i].arm <= 1'b0;
    end

    // one datum in flight per channel keeps each channel's order intact
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        pend_ff[i] <= 1'b0;
      else if (start_fet && pick == 1'(i))
        pend_ff[i] <= 1'b1;
      else if (dep_i)
        pend_ff[i] <= 1'b0;
    end

    // interrupt request pulse after the final deposit
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        irq_ff[i] <= 1'b0;
      else
        irq_ff[i] <= dep_i && is_last && ctrl_ff[i].int_en;
    end
  end

  // ==========================================================================
  // register read port: answer one clock after the read
  // ==========================================================================
  always_comb
  begin
    unique case (pcb_addr[2:0])
      tcd_pkg::REG_SRC_LO: rd_val = src_ff[pcb_addr[3]][15:0];
      tcd_pkg::REG_SRC_HI: rd_val = {12'h000, src_ff[pcb_addr[3]][19:16]};
      tcd_pkg::REG_DST_LO: rd_val = dst_ff[pcb_addr[3]][15:0];
      tcd_pkg::REG_DST_HI: rd_val = {12'h000, dst_ff[pcb_addr[3]][19:16]};
      tcd_pkg::REG_COUNT:  rd_val = cnt_ff[pcb_addr[3]];
      tcd_pkg::REG_CTRL:   rd_val = 16'(ctrl_ff[pcb_addr[3]]);
      default:             rd_val = 16'h0000;  // unused slots read zero
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pcb_rdata_ff <= 16'h0000;
    else if (pcb_sel && !pcb_wr)
      pcb_rdata_ff <= rd_val;
  end

  // ==========================================================================
  // outputs, all from flip-flops
  // ==========================================================================
  assign pcb_rdata     = pcb_rdata_ff;
  assign bus_cmd       = bus_cmd_ff;
  assign bus_cmd_valid = bus_cmd_valid_ff;
  assign dma_owns_bus  = owns_ff;
  assign dma_irq       = irq_ff;

endmodule : tcd_dma

// ### pkg/tcd_pkg.sv
// package: register map, control layout, bus and buffer carriers for the dma controller
package tcd_pkg;

  // ==========================================================================
  // register indices inside one channel's slot (channel is address bit 3)
  // ==========================================================================
  localparam logic [2:0] REG_SRC_LO = 3'h0;
  localparam logic [2:0] REG_SRC_HI = 3'h1;
  localparam logic [2:0] REG_DST_LO = 3'h2;
  localparam logic [2:0] REG_DST_HI = 3'h3;
  localparam logic [2:0] REG_COUNT  = 3'h4;
  localparam logic [2:0] REG_CTRL   = 3'h5;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [19:0] ADDR_RST  = 20'h00000;

  // ==========================================================================
  // timing: each bus cycle lasts at least this many clocks, two per transfer
  // ==========================================================================
  localparam logic [2:0]  CYC_MIN_CLKS = 3'h4;
  localparam logic [1:0]  BUF_DEPTH    = 2'h2;

  // ==========================================================================
  // modes
  // ==========================================================================
  typedef enum logic [1:0] {
    SYNC_NONE = 2'h0,
    SYNC_SRC  = 2'h1,
    SYNC_DST  = 2'h2,
    SYNC_RSVD = 2'h3
  } tcd_sync_t;

  typedef enum logic [1:0] {
    STEP_HOLD = 2'h0,
    STEP_INC  = 2'h1,
    STEP_DEC  = 2'h2,
    STEP_RSVD = 2'h3
  } tcd_step_t;

  typedef enum logic [1:0] {
    RQ_PIN    = 2'h0,
    RQ_TIMER2 = 2'h1,
    RQ_SOFT   = 2'h2,
    RQ_NONE   = 2'h3
  } tcd_rqsrc_t;

  // control register, msb first: field positions follow from this order
  typedef struct packed {
    tcd_rqsrc_t req_src;  // 15:14
    tcd_step_t  dst_step; // 13:12
    logic       dst_io;   // 11
    tcd_step_t  src_step; // 10:9
    logic       src_io;   // 8
    tcd_sync_t  sync;     // 7:6
    logic       prio_hi;  // 5
    logic       term_en;  // 4
    logic       int_en;   // 3
    logic       word;     // 2
    logic       sw_req;   // 1
    logic       arm;      // 0
  } tcd_ctrl_t;

  // one bus cycle handed to the bus interface unit
  typedef struct packed {
    logic [19:0] addr;
    logic        io;
    logic        word;
    logic        write;
    logic [15:0] wdata;
  } tcd_bus_cmd_t;

  // one fetched datum waiting for its deposit
  typedef struct packed {
    logic        ch;
    logic [15:0] data;
  } tcd_buf_ent_t;

endpackage : tcd_pkg

// ### test/tcd_dma_monitor.sv
// checker: bus cycle, interrupt and register port assertions
`timescale 1ns/1ns
module tcd_dma_monitor (
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  input wire logic                  pcb_sel,
  input wire logic                  pcb_wr,
  input wire logic [3:0]            pcb_addr,
  input wire logic [15:0]           pcb_rdata,
  input wire logic                  nmi_req,
  input wire logic                  hold_req,
  input wire logic                  cpu_locked,
  input wire logic                  cpu_odd_split,
  input wire tcd_pkg::tcd_bus_cmd_t bus_cmd,
  input wire logic                  bus_cmd_valid,
  input wire logic                  bus_done,
  input wire logic                  dma_owns_bus,
  input wire logic [1:0]            dma_irq
);
  // ==========================================================================
  // common timing
  // ==========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // blockers stop new cycles, never the running one
  logic stop;
  assign stop = nmi_req | hold_req | cpu_locked | cpu_odd_split;

  sequence owned_four;
    dma_owns_bus [*4];
  endsequence
  sequence waits_done;
    bus_cmd_valid && !bus_done;
  endsequence

  // ==========================================================================
  // assertions
  // ==========================================================================
  min_cycle_a: assert property ($rose(bus_cmd_valid) |-> owned_four)
    else $error("bus cycle shorter than four clocks");
  stop_start_a: assert property (stop [*2] |=> !$rose(bus_cmd_valid))
    else $error("bus cycle started while blocked");
  owns_bus_a: assert property (bus_cmd_valid |-> dma_owns_bus)
    else $error("command without bus ownership");
  cmd_hold_a: assert property (waits_done |=> bus_cmd_valid && $stable(bus_cmd))
    else $error("command changed before completion");
  cmd_drop_a: assert property (bus_cmd_valid && bus_done |=> !bus_cmd_valid)
    else $error("command held after completion");
  irq_pulse_a: assert property (dma_irq != 2'h0 |=> (dma_irq & $past(dma_irq)) == 2'h0)
    else $error("interrupt pulse longer than one cycle");
  irq_end_a: assert property (dma_irq != 2'h0 |-> $fell(dma_owns_bus) && bus_cmd.write)
    else $error("interrupt not at end of deposit");
  unmapped_a: assert property (pcb_sel && !pcb_wr && pcb_addr[2:1] == 2'h3
    |=> pcb_rdata == 16'h0000)
    else $error("unmapped register read not zero");
  hi_half_a: assert property (pcb_sel && !pcb_wr && pcb_addr[2:0] inside {3'h1, 3'h3}
    |=> pcb_rdata[15:4] == 12'h000)
    else $error("upper address half has stray bits");
endmodule : tcd_dma_monitor

bind tcd_dma tcd_dma_monitor u_mon (.clk_sys, .rst_n, .pcb_sel, .pcb_wr, .pcb_addr,
  .pcb_rdata, .nmi_req, .hold_req, .cpu_locked, .cpu_odd_split, .bus_cmd, .bus_cmd_valid,
  .bus_done, .dma_owns_bus, .dma_irq);

// ### test/tcd_bus_model.sv
// partner: bus interface unit answering after a chosen delay
`timescale 1ns/1ns
module tcd_bus_model (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire tcd_pkg::tcd_bus_cmd_t bus_cmd,
  input  wire logic                  bus_cmd_valid,
  input  wire logic [2:0]            lat,
  output logic                       bus_done,
  output logic [15:0]                bus_rdata
);
  logic [2:0]  wait_ff;
  logic        served_ff;
  logic [15:0] noise_ff;

  // one done pulse per command, lat + 1 clocks after it appears
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_ff   <= 3'h0;
      served_ff <= 1'b0;
      bus_done  <= 1'b0;
      noise_ff  <= 16'h1234;
    end
    else
    begin
      noise_ff <= ~noise_ff + 16'h0003;
      bus_done <= 1'b0;
      if (!bus_cmd_valid)
      begin
        wait_ff   <= 3'h0;
        served_ff <= 1'b0;
      end
      else if (bus_done)
        served_ff <= 1'b1;
      else if (!served_ff && wait_ff == lat)
        bus_done <= 1'b1;
      else if (!served_ff)
        wait_ff <= wait_ff + 3'h1;
    end
  end

  // fetched data is a fixed pattern of the address; noise otherwise
  assign bus_rdata = (bus_done && !bus_cmd.write) ? (bus_cmd.addr[15:0] ^ 16'h5a3c) : noise_ff;
endmodule : tcd_bus_model

// ### test/tcd_dma_tb_top.sv
// testbench: registers, transfers, priority, sync and blocking
`timescale 1ns/1ns
module tcd_dma_tb_top;
  logic                  clk_sys, rst_n, pcb_sel, pcb_wr, timer2_out;
  logic                  bus_cmd_valid, bus_done, dma_owns_bus;
  logic                  nmi_req, hold_req, cpu_locked, cpu_odd_split;
  logic [3:0]            pcb_addr, blk;
  logic [15:0]           pcb_wdata, pcb_rdata, bus_rdata, v, n;
  logic [1:0]            channel_request_pins, dma_irq;
  logic [2:0]            lat;
  logic [19:0]           s, d;
  tcd_pkg::tcd_bus_cmd_t bus_cmd;
  logic [31:0]           rd_val, rd_q[$], wr_q[$], wd_q[$];
  integer                seed, num_errors = 0, n_compared = 0, cycles = 0, irq_cnt;

  assign {nmi_req, hold_req, cpu_locked, cpu_odd_split} = blk;

  tcd_dma u_dut (.clk_sys, .rst_n, .pcb_sel, .pcb_wr, .pcb_addr, .pcb_wdata, .pcb_rdata,
    .channel_request_pins, .timer2_out, .nmi_req, .hold_req, .cpu_locked, .cpu_odd_split,
    .bus_cmd, .bus_cmd_valid, .bus_done, .bus_rdata, .dma_owns_bus, .dma_irq);
  tcd_bus_model u_bus (.clk_sys, .rst_n, .bus_cmd, .bus_cmd_valid, .lat, .bus_done, .bus_rdata);

  // clock at 20 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // bus log and hang guard
  // ==========================================================================
  always @(posedge clk_sys)
  begin
    cycles++;
    if (bus_cmd_valid && bus_done && !bus_cmd.write)
      rd_q.push_back(32'({bus_cmd.io, bus_cmd.addr}));
    else if (bus_cmd_valid && bus_done)
    begin
      wr_q.push_back(32'({bus_cmd.io, bus_cmd.addr}));
      wd_q.push_back(32'(bus_cmd.wdata));
    end
    if (|dma_irq)
      irq_cnt++;
    if (cycles == 60000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic reg_acc(input logic wr, input logic [3:0] a, input logic [15:0] dt);
    @(posedge clk_sys);
    pcb_sel   <= 1'b1;
    pcb_wr    <= wr;
    pcb_addr  <= a;
    pcb_wdata <= dt;
    @(posedge clk_sys);
    pcb_sel <= 1'b0;
    #1 rd_val = 32'(pcb_rdata);
  endtask : reg_acc

  // control word: armed, interrupting, one space both sides
  function automatic logic [15:0] mk(input logic [1:0] rq, sy, ss, ds, input logic w, pr, tm, io);
    return {rq, ds, io, ss, io, sy, pr, tm, 1'b1, w, 1'b0, 1'b1};
  endfunction : mk

  function automatic logic [31:0] ea(input logic io, input logic [19:0] a);
    return {11'h000, io, a};
  endfunction : ea

  task automatic prog(input logic c, input logic [19:0] sa, da, input logic [15:0] cn, ct);
    logic [15:0] w [6];
    w = '{sa[15:0], 16'(sa[19:16]), da[15:0], 16'(da[19:16]), cn, ct};
    for (int j = 0; j < 6; j++)
      reg_acc(1'b1, {c, 3'(j)}, w[j]);
  endtask : prog

  task automatic settle(input int cnt);
    repeat (2000)
      if (wr_q.size() < cnt)
        @(posedge clk_sys);
    repeat (40) @(posedge clk_sys);
  endtask : settle

  task automatic fresh;
    rd_q.delete();
    wr_q.delete();
    wd_q.delete();
    irq_cnt = 0;
    lat <= 3'($random(seed));
  endtask : fresh

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    seed = 32'h75ea31d8;
    {pcb_sel, pcb_wr, pcb_addr, pcb_wdata, blk, timer2_out} = '0;
    channel_request_pins = 2'h0;
    lat = 3'h0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    // reset values of all slots
    for (int i = 0; i < 16; i++)
    begin
      reg_acc(1'b0, 4'(i), 16'h0000);
      check(rd_val, 32'h0);
    end
    v = 16'($random(seed));
    reg_acc(1'b1, 4'h9, v);
    reg_acc(1'b0, 4'h9, v);
    check(rd_val, {28'h0, v[3:0]});
    reg_acc(1'b1, 4'h4, v);
    reg_acc(1'b0, 4'h4, v);
    check(rd_val, 32'(v));
    reg_acc(1'b1, 4'h7, v);
    reg_acc(1'b0, 4'h7, v);
    check(rd_val, 32'h0);
    // byte run in i/o space, source up, destination down
    fresh();
    s = 20'($random(seed));
    d = 20'($random(seed));
    n = 16'h2 + 16'($unsigned($random(seed)) % 3);
    prog(1'b0, s, d, n, mk(2'h0, 2'h0, 2'h1, 2'h2, 1'b0, 1'b0, 1'b1, 1'b1));
    settle(int'(n));
    check(wr_q.size(), 32'(n));
    for (int k = 0; k < int'(n); k++)
    begin
      check(rd_q[k], ea(1'b1, s + 20'(k)));
      check(wr_q[k], ea(1'b1, d - 20'(k)));
    end
    reg_acc(1'b0, 4'h4, 16'h0);
    check(rd_val, 32'h0);
    check(irq_cnt, 32'h1);
    // held word moves in memory: data must arrive intact
    fresh();
    prog(1'b1, s, d, 16'h2, mk(2'h0, 2'h0, 2'h0, 2'h0, 1'b1, 1'b0, 1'b1, 1'b0));
    settle(2);
    check(wr_q[1], ea(1'b0, d));
    check(wd_q[1], 32'(s[15:0] ^ 16'h5a3c));
    // no termination: runs until software disarms it
    fresh();
    prog(1'b0, s, d, 16'h1, mk(2'h0, 2'h0, 2'h1, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0));
    settle(3);
    check(32'(wr_q.size() > 2), 32'h1);
    reg_acc(1'b1, 4'h5, 16'h0000);
    repeat (30) @(posedge clk_sys);
    n = 16'(wr_q.size());
    repeat (60) @(posedge clk_sys);
    check(wr_q.size(), 32'(n));
    // alternate, then channel one always first; hold parks both
    for (int p = 0; p < 2; p++)
    begin
      fresh();
      blk <= 4'h4;
      prog(1'b0, 20'h10000, d, 16'h4, mk(2'h0, 2'h0, 2'h1, 2'h1, 1'b0, 1'b0, 1'b1, 1'b0));
      prog(1'b1, 20'h20000, d, 16'h4, mk(2'h0, 2'h0, 2'h1, 2'h1, 1'b0, 1'(p), 1'b1, 1'b0));
      check(rd_q.size(), 32'h0);
      blk <= 4'h0;
      settle(8);
      for (int k = 1; k < 4; k++)
        check(rd_q[k][17], p ? 32'h1 : 32'(!rd_q[k - 1][17]));
    end
    // each blocker in turn: nmi, hold, lock, odd split
    for (int b = 0; b < 4; b++)
    begin
      fresh();
      blk <= 4'h8 >> b;
      prog(1'b0, s, d, 16'h1, mk(2'h0, 2'h0, 2'h1, 2'h1, 1'b1, 1'b0, 1'b1, 1'b0));
      repeat (30) @(posedge clk_sys);
      check(rd_q.size(), 32'h0);
      blk <= 4'h0;
      settle(1);
      check(wr_q.size(), 32'h1);
    end
    // request sources: pin, timer, software
    for (int r = 0; r < 3; r++)
    begin
      fresh();
      v = mk(2'(r), (r == 1) ? 2'h2 : 2'h1, 2'h1, 2'h1, 1'b0, 1'b0, 1'b1, 1'b0);
      prog(1'b0, s, d, 16'h1, v);
      repeat (30) @(posedge clk_sys);
      check(wr_q.size(), 32'h0);
      channel_request_pins <= 2'(r == 0);
      timer2_out <= (r == 1);
      if (r == 2)
        reg_acc(1'b1, 4'h5, v | 16'h0002);
      settle(1);
      check(wr_q.size(), 32'h1);
      channel_request_pins <= 2'h0;
      timer2_out <= 1'b0;
    end
    wrap_up();
  end
endmodule : tcd_dma_tb_top
